/* shared/ahp_pkg.sv */
`default_nettype none
package ahp_pkg;
    localparam int AHP_DATA_W = 8;
    localparam int AHP_ADDR_W = 8;
    localparam int AHP_REG_DEPTH = 256;
    localparam int AHP_NCH = 3;
    localparam logic [AHP_DATA_W-1:0] AHP_REG_RST = 8'h00;

    // Bit positions inside the synchroniser vector
    localparam int SY_CE = 0;
    localparam int SY_WR = 1;
    localparam int SY_RD = 2;
    localparam int SY_FRAME_TRIGGER_IN = 3;
    localparam int SY_HRST = 4;
    localparam int SY_SCL = 5;
    localparam int SY_SDA = 8;
    localparam int SY_W = 11;
    // Idle levels: strobes, chip enable, reset pin and serial lines high, trigger low
    localparam logic [SY_W-1:0] SY_RST_VAL = 11'h7F7;

    // Addresses that steer or report the serial line drivers
    localparam logic [AHP_ADDR_W-1:0] ADDR_SCL_DRV = 8'hF0;
    localparam logic [AHP_ADDR_W-1:0] ADDR_SDA_DRV = 8'hF1;
    localparam logic [AHP_ADDR_W-1:0] ADDR_LINE_SENSE = 8'hF2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WRITE = 2'h1,
        ST_COMMIT = 2'h3,
        ST_READ = 2'h2
    } ahp_state_t;
endpackage : ahp_pkg
`default_nettype wire

/* shared/ahp_sync_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ahp_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    modport src (output raw, input sync);
    modport snk (input raw, output sync);
endinterface : ahp_sync_if
`default_nettype wire

/* logic/ahp_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module ahp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic core_clk_in, // Core clock
    input wire logic rst_in,      // Async reset, active high
    ahp_sync_if.snk sy            // Raw levels in, synchronised levels out
);
    logic [W-1:0] stage1;

    // Stage one feeds stage two only
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            stage1 <= RST_VAL;
            sy.sync <= RST_VAL;
        end else begin
            stage1 <= sy.raw;
            sy.sync <= stage1;
        end
    end
endmodule : ahp_sync
`default_nettype wire

/* logic/ahp_top.sv */
// Overview of operation
// - Write strobe with chip enable loads addressed register
// - Read starts at read strobe falling edge
// - Drive data only while read and enable low
// - Chip enable high keeps data lines released
// - Interrupt output open-drain, only pulls low
// - Low reset pin returns device to power-on
// - Trigger assertion starts a new frame
// - Serial lines open-drain driven and sensed
// - Address captured when strobe falls, enable low
`timescale 1ns/1ps
`default_nettype none
module ahp_top (
    input wire logic core_clk_in,                                // Core clock, 20 MHz
    input wire logic rst_in,                                     // Async reset, active high
    input wire logic host_reset_n_in,                            // Reset pin, active low
    input wire logic chip_en_n_in,                               // Chip enable, active low
    input wire logic wr_n_in,                                    // Write strobe, active low
    input wire logic rd_n_in,                                    // Read strobe, active low
    input wire logic [ahp_pkg::AHP_ADDR_W-1:0] addr_in,          // Address bus
    input wire logic [ahp_pkg::AHP_DATA_W-1:0] data_in,          // Data bus input
    output logic [ahp_pkg::AHP_DATA_W-1:0] data_out,             // Data bus output
    output logic data_oe_n_out,                                  // Data bus enable, low drives
    input wire logic irq_req_in,                                 // Interrupt request from core
    output logic irq_n_out,                                      // Interrupt pin level when enabled
    output logic irq_oe_n_out,                                   // Interrupt pin enable, low pulls
    input wire logic frame_trigger_in,                           // Frame trigger pin
    output logic frame_start_out,                                // New frame pulse
    input wire logic [ahp_pkg::AHP_NCH-1:0] ch_serial_clock_in,  // Serial clock line levels
    input wire logic [ahp_pkg::AHP_NCH-1:0] ch_serial_data_in,   // Serial data line levels
    output logic [ahp_pkg::AHP_NCH-1:0] ch_serial_clock_out,     // Serial clock drive level
    output logic [ahp_pkg::AHP_NCH-1:0] ch_serial_clock_oe_n_out,// Serial clock enable, low pulls
    output logic [ahp_pkg::AHP_NCH-1:0] ch_serial_data_out,      // Serial data drive level
    output logic [ahp_pkg::AHP_NCH-1:0] ch_serial_data_oe_n_out, // Serial data enable, low pulls
    output logic wr_strobe_out,                                  // Register write pulse
    output logic [ahp_pkg::AHP_ADDR_W-1:0] wr_addr_out,          // Written address
    output logic [ahp_pkg::AHP_DATA_W-1:0] wr_data_out,          // Written value
    output logic rd_strobe_out,                                  // Register read pulse
    output logic [ahp_pkg::AHP_ADDR_W-1:0] rd_addr_out           // Read address
);
    import ahp_pkg::*;

    ahp_sync_if #(.W(SY_W)) sy ();
    logic [SY_W-1:0] prev;
    logic [AHP_DATA_W-1:0] regs [AHP_REG_DEPTH];
    logic [AHP_DATA_W-1:0] wr_latch;
    ahp_state_t state;
    ahp_state_t next_state;
    logic dev_rst;
    logic ce_s, wr_s, rd_s, frame_trigger_in_s;
    logic wr_fall, wr_rise, rd_fall, rd_end;

    function automatic logic [AHP_DATA_W-1:0] reg_rd(input logic [AHP_ADDR_W-1:0] a,
                                                     input logic [SY_W-1:0] lv);
        if (a == ADDR_LINE_SENSE)
            reg_rd = {2'h0, lv[SY_SDA +: AHP_NCH], lv[SY_SCL +: AHP_NCH]};
        else
            reg_rd = regs[a];
    endfunction : reg_rd

    assign sy.raw = {ch_serial_data_in, ch_serial_clock_in, host_reset_n_in,
                     frame_trigger_in, rd_n_in, wr_n_in, chip_en_n_in};

    ahp_sync #(.W(SY_W), .RST_VAL(SY_RST_VAL)) u_sync (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .sy(sy)
    );

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            prev <= SY_RST_VAL;
        end else begin
            prev <= sy.sync;
        end
    end

    assign dev_rst = !sy.sync[SY_HRST];
    assign ce_s = sy.sync[SY_CE];
    assign wr_s = sy.sync[SY_WR];
    assign rd_s = sy.sync[SY_RD];
    assign frame_trigger_in_s = sy.sync[SY_FRAME_TRIGGER_IN];
    // Edges are taken from synchronised levels only
    assign wr_fall = prev[SY_WR] && !wr_s;
    assign wr_rise = !prev[SY_WR] && wr_s;
    assign rd_fall = prev[SY_RD] && !rd_s;
    assign rd_end = rd_s || ce_s;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                // Chip enable is sampled with the strobe, so it may fall together with it
                if (wr_fall && !ce_s) begin
                    next_state = ST_WRITE;
                end else if (rd_fall && !ce_s) begin
                    next_state = ST_READ;
                end
            end
            // Commit on strobe release whatever chip enable does meanwhile
            ST_WRITE: begin
                if (wr_rise) begin
                    next_state = ST_COMMIT;
                end
            end
            ST_COMMIT: begin
                next_state = ST_IDLE;
            end
            ST_READ: begin
                if (rd_end) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= ST_IDLE;
        end else if (dev_rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Data is followed on the raw pins while strobe and chip enable are low; the synced rise
    // arrives late, when the host may already have moved the bus
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_latch <= AHP_REG_RST;
        end else if (!wr_n_in && !chip_en_n_in) begin
            wr_latch <= data_in;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_addr_out <= '0;
            wr_data_out <= AHP_REG_RST;
            wr_strobe_out <= 1'b0;
        end else if (dev_rst) begin
            wr_addr_out <= '0;
            wr_data_out <= AHP_REG_RST;
            wr_strobe_out <= 1'b0;
        end else begin
            wr_strobe_out <= (state == ST_WRITE) && wr_rise;
            if (state == ST_IDLE && wr_fall && !ce_s) begin
                wr_addr_out <= addr_in;
            end
            if (state == ST_WRITE && wr_rise) begin
                wr_data_out <= wr_latch;
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < AHP_REG_DEPTH; i++) begin
                regs[i] <= AHP_REG_RST;
            end
        end else if (dev_rst) begin
            for (int i = 0; i < AHP_REG_DEPTH; i++) begin
                regs[i] <= AHP_REG_RST;
            end
        end else if (state == ST_WRITE && wr_rise) begin
            regs[wr_addr_out] <= wr_latch;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            data_out <= AHP_REG_RST;
            rd_addr_out <= '0;
            rd_strobe_out <= 1'b0;
        end else if (dev_rst) begin
            data_out <= AHP_REG_RST;
            rd_addr_out <= '0;
            rd_strobe_out <= 1'b0;
        end else begin
            rd_strobe_out <= (state == ST_IDLE) && rd_fall && !ce_s && !(wr_fall && !ce_s);
            if (state == ST_IDLE && rd_fall && !ce_s && !(wr_fall && !ce_s)) begin
                data_out <= reg_rd(addr_in, sy.sync);
                rd_addr_out <= addr_in;
            end
        end
    end

    // Enable follows the pins directly so the bus is released at once
    assign data_oe_n_out = chip_en_n_in || rd_n_in || dev_rst;

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_oe_n_out <= 1'b1;
        end else begin
            irq_oe_n_out <= !irq_req_in || dev_rst;
        end
    end
    assign irq_n_out = 1'b0;

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            frame_start_out <= 1'b0;
        end else begin
            frame_start_out <= frame_trigger_in_s && !prev[SY_FRAME_TRIGGER_IN] && !dev_rst;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ch_serial_clock_oe_n_out <= '1;
            ch_serial_data_oe_n_out <= '1;
        end else begin
            ch_serial_clock_oe_n_out <= ~regs[ADDR_SCL_DRV][AHP_NCH-1:0];
            ch_serial_data_oe_n_out <= ~regs[ADDR_SDA_DRV][AHP_NCH-1:0];
        end
    end
    assign ch_serial_clock_out = '0;
    assign ch_serial_data_out = '0;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_wr_open;
        state == ST_IDLE && wr_fall && !ce_s;
    endsequence
    sequence s_wr_close;
        state == ST_WRITE && wr_rise;
    endsequence

    a_oe_ce_high: assert property (chip_en_n_in |-> data_oe_n_out)
        else $error("data driven while chip enable high");
    a_oe_read_drive: assert property (!chip_en_n_in && !rd_n_in && !dev_rst |-> !data_oe_n_out)
        else $error("data not driven during read");
    a_wr_open_addr: assert property (s_wr_open |=> state == ST_WRITE && wr_addr_out == $past(addr_in))
        else $error("write address not captured");
    a_wr_commit_reg: assert property (s_wr_close |=> wr_strobe_out && regs[wr_addr_out] == wr_data_out)
        else $error("write not committed");
    a_wr_ce_free: assert property (s_wr_close and ce_s |=> wr_strobe_out)
        else $error("write lost when enable rose with strobe");
    a_rd_load_data: assert property (state == ST_IDLE && rd_fall && !ce_s && !wr_fall
        |=> rd_strobe_out && data_out == $past(reg_rd(addr_in, sy.sync)))
        else $error("read data not loaded");
    a_irq_pull_only: assert property (irq_n_out == 1'b0 && (irq_oe_n_out == !$past(irq_req_in) || $past(dev_rst)))
        else $error("interrupt pin misdriven");
    a_frame_trigger_in_frame: assert property (frame_start_out |-> $past(frame_trigger_in, 3) && !$past(frame_start_out))
        else $error("frame start without trigger");
    a_host_reset: assert property (dev_rst |=> state == ST_IDLE && !wr_strobe_out && !frame_start_out)
        else $error("reset pin did not clear state");
    a_serial_od: assert property (ch_serial_clock_out == '0 && ch_serial_data_out == '0
        && ch_serial_clock_oe_n_out == ~$past(regs[ADDR_SCL_DRV][AHP_NCH-1:0]))
        else $error("serial line not open drain");
endmodule : ahp_top
`default_nettype wire

/* tb/ahp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ahp_host_model
    import ahp_pkg::*;
(
    input wire logic core_clk_in,             // Pacing clock
    input wire logic [AHP_DATA_W-1:0] bus_in, // Resolved data bus
    input wire logic bus_oe_n_in,             // Device drive enable
    output logic chip_en_n_out,               // Chip enable
    output logic wr_n_out,                    // Write strobe
    output logic rd_n_out,                    // Read strobe
    output logic [AHP_ADDR_W-1:0] addr_out,   // Address
    output logic [AHP_DATA_W-1:0] data_out    // Host data drive
);
    // Test pins are not modelled; the board holds them at normal levels
    initial begin
        chip_en_n_out = 1'b1;
        wr_n_out = 1'b1;
        rd_n_out = 1'b1;
        addr_out = 8'h00;
        data_out = 8'hFF;
    end

    // Style 0 holds enable across, 1 moves it with the strobe, 2 leaves it high,
    // 3 is style 1 with the read strobe moving alongside
    task automatic write(input logic [7:0] a, input logic [7:0] d, input int style);
        @(negedge core_clk_in);
        addr_out = a;
        data_out = d;
        if (style == 0) begin
            chip_en_n_out = 1'b0;
            @(negedge core_clk_in);
        end
        wr_n_out = 1'b0;
        if (style == 1 || style == 3) chip_en_n_out = 1'b0;
        if (style == 3) rd_n_out = 1'b0;
        repeat (4) @(negedge core_clk_in);
        wr_n_out = 1'b1;
        if (style == 1 || style == 3) chip_en_n_out = 1'b1;
        if (style == 3) rd_n_out = 1'b1;
        if (style == 0) begin
            @(negedge core_clk_in);
            chip_en_n_out = 1'b1;
        end
        // Inverse after release so a stale value cannot pass
        data_out = ~d;
        addr_out = ~a;
    endtask : write

    task automatic read(input logic [7:0] a, input int style, output logic [7:0] d, output logic oe_n);
        @(negedge core_clk_in);
        addr_out = a;
        if (style == 0) chip_en_n_out = 1'b0;
        rd_n_out = 1'b0;
        if (style == 1) chip_en_n_out = 1'b0;
        repeat (5) @(negedge core_clk_in);
        d = bus_in;
        oe_n = bus_oe_n_in;
        rd_n_out = 1'b1;
        chip_en_n_out = 1'b1;
        addr_out = ~a;
    endtask : read
endmodule : ahp_host_model
`default_nettype wire

/* tb/async_host_port_pins_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module async_host_port_pins_tb_top
    import ahp_pkg::*;
;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic host_reset_n_in = 1'b1;
    logic irq_req_in = 1'b0;
    logic frame_trigger_in = 1'b0;
    logic ce_n, wr_n, rd_n, data_oe_n_out, irq_n_out, irq_oe_n_out, frame_start_out;
    logic wr_strobe_out, rd_strobe_out;
    logic [7:0] addr, hdata, data_out, bus, wr_addr_out, wr_data_out, rd_addr_out;
    logic [2:0] scl_out, scl_oe_n, sda_out, sda_oe_n;
    int error_cnt = 0;
    int total_checks = 0;

    always #25 core_clk_in = ~core_clk_in;
    assign bus = data_oe_n_out ? 8'hZZ : data_out;
    // Open-drain lines with pull-ups
    wire logic [2:0] scl_line = scl_oe_n | scl_out;
    wire logic [2:0] sda_line = sda_oe_n | sda_out;

    ahp_top u_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .host_reset_n_in(host_reset_n_in),
        .chip_en_n_in(ce_n), .wr_n_in(wr_n), .rd_n_in(rd_n), .addr_in(addr), .data_in(hdata),
        .data_out(data_out), .data_oe_n_out(data_oe_n_out), .irq_req_in(irq_req_in),
        .irq_n_out(irq_n_out), .irq_oe_n_out(irq_oe_n_out), .frame_trigger_in(frame_trigger_in),
        .frame_start_out(frame_start_out), .ch_serial_clock_in(scl_line), .ch_serial_data_in(sda_line),
        .ch_serial_clock_out(scl_out), .ch_serial_clock_oe_n_out(scl_oe_n), .ch_serial_data_out(sda_out),
        .ch_serial_data_oe_n_out(sda_oe_n), .wr_strobe_out(wr_strobe_out), .wr_addr_out(wr_addr_out),
        .wr_data_out(wr_data_out), .rd_strobe_out(rd_strobe_out), .rd_addr_out(rd_addr_out));

    ahp_host_model host (.core_clk_in(core_clk_in), .bus_in(bus), .bus_oe_n_in(data_oe_n_out),
        .chip_en_n_out(ce_n), .wr_n_out(wr_n), .rd_n_out(rd_n), .addr_out(addr), .data_out(hdata));

    task automatic summarize;
        if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : summarize

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Bounded wait for a pulse: 0 write, 1 read, 2 frame start
    task automatic wait_evt(input int which);
        logic hit;
        hit = 1'b0;
        for (int n = 0; n < 10 && !hit; n++) begin
            @(negedge core_clk_in);
            case (which)
                0: hit = (wr_strobe_out === 1'b1);
                1: hit = (rd_strobe_out === 1'b1);
                default: hit = (frame_start_out === 1'b1);
            endcase
        end
        if (!hit) begin
            error_cnt++;
            $display("mismatch at %0t: pulse %0d missing", $time, which);
            summarize();
        end
    endtask : wait_evt

    task automatic do_write(input logic [7:0] a, input logic [7:0] d, input int style);
        host.write(a, d, style);
        wait_evt(0);
        chk(wr_addr_out, a);
        chk(wr_data_out, d);
        repeat (4) @(negedge core_clk_in);
    endtask : do_write

    task automatic do_read(input logic [7:0] a, input int style, input logic [7:0] exp);
        logic [7:0] d;
        logic oe;
        fork
            host.read(a, style, d, oe);
            wait_evt(1);
        join
        chk(rd_addr_out, a);
        chk(d, exp);
        chk({7'h00, oe}, 8'h00);
        @(negedge core_clk_in);
        chk({7'h00, data_oe_n_out}, 8'h01);
        repeat (3) @(negedge core_clk_in);
    endtask : do_read

    task automatic t_access;
        do_write(8'h5A, 8'hA5, 0);
        do_write(8'hFF, 8'h01, 1);
        do_write(8'h00, 8'h80, 1);
        do_read(8'h5A, 0, 8'hA5);
        do_read(8'hFF, 1, 8'h01);
        do_read(8'h00, 0, 8'h80);
    endtask : t_access

    task automatic t_refused;
        logic [7:0] d;
        logic oe;
        logic seen;
        seen = 1'b0;
        host.write(8'h33, 8'h77, 2);
        repeat (6) begin
            @(negedge core_clk_in);
            if (wr_strobe_out !== 1'b0) seen = 1'b1;
        end
        chk({7'h00, seen}, 8'h00);
        host.read(8'h5A, 2, d, oe);
        chk({7'h00, oe}, 8'h01);
        repeat (4) @(negedge core_clk_in);
        do_read(8'h33, 1, 8'h00);
    endtask : t_refused

    // Write and read strobes falling together: the write wins, no read starts
    task automatic t_collide;
        logic seen;
        seen = 1'b0;
        fork
            host.write(8'h44, 8'h99, 3);
            repeat (12) begin
                @(negedge core_clk_in);
                if (rd_strobe_out !== 1'b0) seen = 1'b1;
            end
        join
        chk({7'h00, seen}, 8'h00);
        do_read(8'h44, 0, 8'h99);
    endtask : t_collide

    task automatic t_serial;
        do_write(ADDR_SCL_DRV, 8'h05, 0);
        do_write(ADDR_SDA_DRV, 8'h03, 1);
        chk({5'h00, scl_oe_n}, 8'h02);
        chk({5'h00, sda_oe_n}, 8'h04);
        chk({2'h0, sda_out, scl_out}, 8'h00);
        do_read(ADDR_LINE_SENSE, 0, 8'h22);
    endtask : t_serial

    task automatic t_reset_pin;
        irq_req_in = 1'b1;
        host_reset_n_in = 1'b0;
        repeat (4) @(negedge core_clk_in);
        chk({7'h00, irq_oe_n_out}, 8'h01);
        host_reset_n_in = 1'b1;
        irq_req_in = 1'b0;
        repeat (4) @(negedge core_clk_in);
        chk({2'h0, sda_oe_n, scl_oe_n}, 8'h3F);
        do_read(8'h5A, 0, 8'h00);
    endtask : t_reset_pin

    task automatic t_irq;
        irq_req_in = 1'b1;
        @(negedge core_clk_in);
        chk({6'h00, irq_oe_n_out, irq_n_out}, 8'h00);
        irq_req_in = 1'b0;
        @(negedge core_clk_in);
        chk({6'h00, irq_oe_n_out, irq_n_out}, 8'h02);
    endtask : t_irq

    task automatic t_trigger;
        repeat (2) begin
            frame_trigger_in = 1'b1;
            wait_evt(2);
            @(negedge core_clk_in);
            chk({7'h00, frame_start_out}, 8'h00);
            frame_trigger_in = 1'b0;
            repeat (2) @(negedge core_clk_in);
        end
    endtask : t_trigger

    initial begin
        repeat (10) @(negedge core_clk_in);
        rst_in = 1'b0;
        repeat (3) @(negedge core_clk_in);
        t_access();
        t_refused();
        t_collide();
        t_irq();
        t_trigger();
        t_serial();
        t_reset_pin();
        summarize();
    end
endmodule : async_host_port_pins_tb_top
`default_nettype wire
